// File: spisd_pkg.sv
// Constants for the serial status and data register block
package spisd_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_ONE = 8'h00;
  localparam logic [7:0] IDX_CTRL_TWO = 8'h01;
  localparam logic [7:0] IDX_BAUD = 8'h02;
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam logic [7:0] IDX_DATA_HIGH = 8'h04;
  localparam logic [7:0] IDX_DATA_LOW = 8'h05;
  localparam logic [7:0] IDX_EVENT = 8'h06;
  localparam logic [7:0] IDX_MASK = 8'h07;
  localparam logic [7:0] IDX_DATA_WORD = 8'h08;
  // Status bit positions
  localparam int ST_RX_FULL = 7;
  localparam int ST_TX_EMPTY = 5;
  localparam int ST_MODE_FAULT = 4;
  // Control one / two bit positions
  localparam int C1_IRQ_EN = 7;
  localparam int C1_ENABLE = 6;
  localparam int C1_MASTER = 4;
  localparam int C2_WIDTH = 6;
  localparam int C2_FAULT_EN = 4;
  // Event bit positions
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_FAULT = 2;
  // Reset values, word lengths and engine states
  localparam logic [7:0] RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_CTRL_TWO = 8'h00;
  localparam logic [7:0] RST_BAUD = 8'h03;
  localparam logic [15:0] RST_DATA = 16'h0000;
  localparam logic [4:0] BITS_NARROW = 5'h08;
  localparam logic [4:0] BITS_WIDE = 5'h10;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT} spisd_state_e;
endpackage

// File: spisd_top.sv
// Serial status flags, data register and shift engine with APB access
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module spisd_top
  import spisd_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Serial link
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe_n,
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe_n,
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe_n,
  input wire logic i_slave_select_n,
  // Interrupt
  output logic o_irq
);

  function automatic logic [4:0] word_bits(input logic wide);
    word_bits = wide ? BITS_WIDE : BITS_NARROW;
  endfunction

  function automatic logic top_bit(input logic [15:0] v, input logic wide);
    top_bit = wide ? v[15] : v[7];
  endfunction

  // Bus decode
  logic [7:0] idx;
  logic mapped;
  logic acc;
  logic wr;
  logic rd;
  assign idx = i_paddr[9:2];
  assign mapped = (i_paddr[31:10] == 22'h000000) && (i_paddr[1:0] == 2'h0) && (idx <= IDX_DATA_WORD);
  assign acc = i_psel && i_penable && !o_pready && mapped;
  assign wr = acc && i_pwrite;
  assign rd = acc && !i_pwrite;

  logic [7:0] ctrl_one_q;
  logic [7:0] ctrl_two_q;
  logic [7:0] baud_q;
  logic [2:0] event_q;
  logic [2:0] mask_q;
  logic rx_full_q;
  logic tx_empty_q;
  logic fault_q;
  logic rx_arm_q;
  logic tx_arm_q;
  logic fault_arm_q;
  logic [15:0] rx_data_q;
  logic [15:0] tx_data_q;
  logic [15:0] held_q;
  logic held_valid_q;
  logic [7:0] status;
  logic wide;
  logic enabled;
  logic master;
  assign wide = ctrl_two_q[C2_WIDTH];
  assign enabled = ctrl_one_q[C1_ENABLE];
  assign master = ctrl_one_q[C1_MASTER];
  // Unassigned bits stay zero
  always_comb
  begin
    status = 8'h00;
    status[ST_RX_FULL] = rx_full_q;
    status[ST_TX_EMPTY] = tx_empty_q;
    status[ST_MODE_FAULT] = fault_q;
  end

  // Link input synchronisers
  logic sck_s1_q, sck_s2_q, sck_s3_q;
  logic mosi_s1_q, mosi_s2_q;
  logic miso_s1_q, miso_s2_q;
  logic ss_s1_q, ss_s2_q, ss_s3_q;
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      {sck_s1_q, sck_s2_q, sck_s3_q} <= 3'h0;
      {mosi_s1_q, mosi_s2_q, miso_s1_q, miso_s2_q} <= 4'h0;
      {ss_s1_q, ss_s2_q, ss_s3_q} <= 3'h7;
    end
    else
    begin
      {sck_s1_q, sck_s2_q, sck_s3_q} <= {i_sck, sck_s1_q, sck_s2_q};
      {mosi_s1_q, mosi_s2_q} <= {i_mosi, mosi_s1_q};
      {miso_s1_q, miso_s2_q} <= {i_miso, miso_s1_q};
      {ss_s1_q, ss_s2_q, ss_s3_q} <= {i_slave_select_n, ss_s1_q, ss_s2_q};
    end
  end

  // Shift engine
  spisd_state_e state_q;
  logic [15:0] shift_q;
  logic [4:0] bit_cnt_q;
  logic [7:0] div_cnt_q;
  logic sck_q;
  logic out_q;
  logic tick;
  logic fault_hit;
  logic m_start;
  logic s_start;
  logic start;
  logic word_done;
  logic slave_rise;
  logic slave_fall;
  assign tick = (div_cnt_q == 8'h00);
  assign fault_hit = enabled && master && ctrl_two_q[C2_FAULT_EN] && !ss_s2_q;
  assign m_start = enabled && master && !fault_hit && state_q == ST_IDLE && !tx_empty_q;
  assign s_start = enabled && !master && !ss_s2_q && ss_s3_q;
  assign start = m_start || s_start;
  assign slave_rise = enabled && !master && !ss_s2_q && sck_s2_q && !sck_s3_q;
  assign slave_fall = enabled && !master && !ss_s2_q && !sck_s2_q && sck_s3_q;

  always_ff @(posedge i_clock)
  begin
    if (i_reset || state_q == ST_IDLE || tick)
      div_cnt_q <= RST_BAUD;
    else
      div_cnt_q <= div_cnt_q - 8'h01;
  end

  always_comb
  begin
    word_done = 1'b0;
    if (state_q == ST_SHIFT && !fault_hit)
    begin
      if (master)
        word_done = tick && sck_q && bit_cnt_q == word_bits(wide);
      else
        word_done = slave_rise && bit_cnt_q == word_bits(wide) - 5'h01;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      state_q <= ST_IDLE;
      shift_q <= RST_DATA;
      bit_cnt_q <= 5'h00;
      sck_q <= 1'b0;
      out_q <= 1'b0;
    end
    else if (fault_hit || !enabled || (!master && ss_s2_q))
    begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 5'h00;
      sck_q <= 1'b0;
    end
    else if (start)
    begin
      state_q <= ST_SHIFT;
      shift_q <= tx_data_q;
      out_q <= top_bit(tx_data_q, wide);
      bit_cnt_q <= 5'h00;
    end
    else if (state_q == ST_SHIFT && master && tick)
    begin
      sck_q <= !sck_q;
      if (!sck_q)
      begin
        shift_q <= {shift_q[14:0], miso_s2_q};
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      else if (word_done)
        state_q <= ST_IDLE;
      else
        out_q <= top_bit(shift_q, wide);
    end
    else if (state_q == ST_SHIFT && slave_rise)
    begin
      shift_q <= {shift_q[14:0], mosi_s2_q};
      bit_cnt_q <= word_done ? 5'h00 : bit_cnt_q + 5'h01;
      if (word_done)
        state_q <= ST_IDLE;
    end
    else if (state_q == ST_SHIFT && slave_fall)
      out_q <= top_bit(shift_q, wide);
  end

  // Received word, masked to the active width
  logic [15:0] rx_word;
  assign rx_word = wide ? {shift_q[14:0], mosi_s2_q} : {8'h00, shift_q[6:0], mosi_s2_q};
  logic [15:0] m_word;
  assign m_word = wide ? shift_q : {8'h00, shift_q[7:0]};
  logic [15:0] done_word;
  assign done_word = master ? m_word : rx_word;

  // Flag servicing sequences
  logic rx_service;
  logic tx_service;
  logic data_wr_low;
  logic data_wr_high;
  logic rd_low;
  logic rd_high;
  assign rd_low = rd && (idx == IDX_DATA_LOW || idx == IDX_DATA_WORD);
  assign rd_high = rd && idx == IDX_DATA_HIGH;
  assign rx_service = rd_low && rx_arm_q && rx_full_q;
  assign data_wr_low = wr && (idx == IDX_DATA_LOW || idx == IDX_DATA_WORD);
  assign data_wr_high = wr && idx == IDX_DATA_HIGH;
  assign tx_service = data_wr_low && tx_arm_q && tx_empty_q;

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      rx_arm_q <= 1'b0;
      tx_arm_q <= 1'b0;
      fault_arm_q <= 1'b0;
    end
    else if (rd && idx == IDX_STATUS)
    begin
      rx_arm_q <= rx_full_q;
      tx_arm_q <= tx_empty_q;
      fault_arm_q <= fault_q;
    end
    else
    begin
      if (rx_service)
        rx_arm_q <= 1'b0;
      if (tx_service)
        tx_arm_q <= 1'b0;
      if (wr && idx == IDX_CTRL_ONE)
        fault_arm_q <= 1'b0;
    end
  end

  // Receive side
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      rx_full_q <= 1'b0;
      rx_data_q <= RST_DATA;
      held_q <= RST_DATA;
      held_valid_q <= 1'b0;
    end
    else
    begin
      if (word_done && (!rx_full_q || rx_service))
      begin
        rx_full_q <= 1'b1;
        rx_data_q <= done_word;
      end
      else if (word_done)
      begin
        held_q <= done_word;
        held_valid_q <= 1'b1;
      end
      else if (rx_service && held_valid_q)
      begin
        rx_data_q <= held_q;
        held_valid_q <= 1'b0;
      end
      else if (rx_service)
        rx_full_q <= 1'b0;
      else if (start)
        held_valid_q <= 1'b0;
    end
  end

  // Transmit buffer; low-only wide write keeps the old high byte
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      tx_empty_q <= 1'b1;
      tx_data_q <= RST_DATA;
    end
    else
    begin
      if (tx_empty_q && data_wr_high)
        tx_data_q[15:8] <= i_pwdata[7:0];
      if (tx_empty_q && wr && idx == IDX_DATA_WORD)
        tx_data_q[15:8] <= i_pwdata[15:8];
      if (tx_empty_q && data_wr_low)
        tx_data_q[7:0] <= i_pwdata[7:0];
      if (start)
        tx_empty_q <= 1'b1;
      else if (tx_service)
        tx_empty_q <= 1'b0;
    end
  end

  // Control and mode fault; fault overrides a control one write to the master bit
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      ctrl_one_q <= RST_CTRL_ONE;
      ctrl_two_q <= RST_CTRL_TWO;
      baud_q <= RST_BAUD;
      fault_q <= 1'b0;
    end
    else
    begin
      if (wr && idx == IDX_CTRL_ONE)
        ctrl_one_q <= i_pwdata[7:0];
      if (wr && idx == IDX_CTRL_TWO)
        ctrl_two_q <= i_pwdata[7:0];
      if (wr && idx == IDX_BAUD)
        baud_q <= i_pwdata[7:0];
      if (fault_hit)
      begin
        fault_q <= 1'b1;
        ctrl_one_q[C1_MASTER] <= 1'b0;
      end
      else if (wr && idx == IDX_CTRL_ONE && fault_arm_q && fault_q)
        fault_q <= 1'b0;
    end
  end

  // Events, set wins over write-one clear
  logic [2:0] ev_set;
  assign ev_set = {fault_hit && !fault_q, start && master, word_done};
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      event_q <= 3'h0;
      mask_q <= 3'h0;
    end
    else
    begin
      if (wr && idx == IDX_EVENT)
        event_q <= (event_q & ~i_pwdata[2:0]) | ev_set;
      else
        event_q <= event_q | ev_set;
      if (wr && idx == IDX_MASK)
        mask_q <= i_pwdata[2:0];
    end
  end
  assign o_irq = ctrl_one_q[C1_IRQ_EN] && |(event_q & mask_q);

  // APB answer, one wait state
  logic [31:0] rdata;
  always_comb
  begin
    rdata = 32'h00000000;
    case (idx)
      IDX_CTRL_ONE: rdata[7:0] = ctrl_one_q;
      IDX_CTRL_TWO: rdata[7:0] = ctrl_two_q;
      IDX_BAUD: rdata[7:0] = baud_q;
      IDX_STATUS: rdata[7:0] = status;
      IDX_DATA_HIGH: rdata[7:0] = rx_data_q[15:8];
      IDX_DATA_LOW: rdata[7:0] = rx_data_q[7:0];
      IDX_EVENT: rdata[2:0] = event_q;
      IDX_MASK: rdata[2:0] = mask_q;
      IDX_DATA_WORD: rdata[15:0] = rx_data_q;
      default: rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end
    else
    begin
      o_pready <= i_psel && i_penable && !o_pready;
      o_pslverr <= i_psel && i_penable && !o_pready && !mapped;
      if (rd)
        o_prdata <= rdata;
    end
  end

  // Pin drive; slave output released while deselected
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_sck_oe_n <= 1'b1;
      o_mosi_oe_n <= 1'b1;
      o_miso_oe_n <= 1'b1;
    end
    else
    begin
      o_sck_oe_n <= !(enabled && master && !fault_hit);
      o_mosi_oe_n <= !(enabled && master && !fault_hit);
      // Fault keeps the slave output off until software clears it
      o_miso_oe_n <= !(enabled && !master && !ss_s2_q && !fault_q);
    end
  end
  assign o_sck = sck_q;
  assign o_mosi = out_q;
  assign o_miso = out_q;

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence status_then_low;
    rd && idx == IDX_STATUS && rx_full_q ##[1:8] rd_low;
  endsequence

  rx_fill_a: assert property (word_done && !rx_full_q |=> rx_full_q && rx_data_q == $past(done_word))
    else $error("received word not loaded");
  tx_empty_a: assert property (start |=> tx_empty_q)
    else $error("transmit empty not set after load");
  fault_set_a: assert property (fault_hit |=> fault_q && !master && state_q == ST_IDLE ##1 o_sck_oe_n && o_miso_oe_n)
    else $error("mode fault not handled");
  fault_clr_a: assert property (wr && idx == IDX_CTRL_ONE && fault_arm_q && fault_q && !fault_hit |=> !fault_q)
    else $error("mode fault not cleared");
  status_ro_a: assert property (wr && idx == IDX_STATUS && !word_done && !start && !fault_hit |=> $stable(status))
    else $error("status changed by write");
  rx_clear_a: assert property (status_then_low ##0 rx_service && !held_valid_q && !word_done |=> !rx_full_q)
    else $error("receive full not cleared");
  high_read_a: assert property (rd_high && !word_done |=> rx_full_q == $past(rx_full_q))
    else $error("high read changed receive full");
  tx_ignore_a: assert property (!tx_empty_q && wr |=> $stable(tx_data_q))
    else $error("write accepted while full");
  queue_go_a: assert property (m_start |=> state_q == ST_SHIFT)
    else $error("queued word not started");
  held_move_a: assert property (rx_service && held_valid_q && !word_done |=> rx_full_q && !held_valid_q)
    else $error("held word not moved");
  held_drop_a: assert property (start && held_valid_q && !rx_service |=> !held_valid_q && $stable(rx_data_q))
    else $error("stale held word kept");
endmodule

// File: spisd_link_slave.sv
// Behavioural external serial slave, mode 0, MSB first
`timescale 1ns/1ps
module spisd_link_slave (
  // Link
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_wide,
  output logic o_miso,
  // Observation
  output int o_count,
  output logic [15:0] o_last
);
  logic [15:0] sh_q;
  logic [15:0] rx_q;
  logic [15:0] rep;
  int bits;
  initial
  begin
    o_count = 0;
    bits = 0;
    o_last = 16'h0000;
    rx_q = 16'h0000;
    sh_q = 16'h0000;
  end
  // Reply changes with every frame so a stale word is caught
  assign rep = i_wide ? {8'hC3, 8'h50 + o_count[7:0]} : {8'h50 + o_count[7:0], 8'h00};
  assign o_miso = (bits == 0) ? rep[15] : sh_q[15];
  // Sample on the rising edge
  always @(posedge i_sck)
  begin
    if (bits == 0)
      sh_q = rep;
    rx_q = {rx_q[14:0], i_mosi};
    bits++;
    if (bits == (i_wide ? 16 : 8))
    begin
      o_last = rx_q;
      o_count++;
      bits = 0;
    end
  end
  // Next bit on the falling edge
  always @(negedge i_sck)
    sh_q = sh_q << 1;
endmodule

// File: tb_spi_status_and_data_regs.sv
// Self-checking bench: APB register access, master and slave transfers, mode fault
`timescale 1ns/1ps
module tb_spi_status_and_data_regs;
  import spisd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  localparam logic [7:0] SLV_IN = 8'hC6;
  logic ss_n = 1'b1;
  logic wide = 1'b0;
  logic s_sck = 1'b0;
  logic s_mosi = 1'b0;
  logic [7:0] got;
  int b;
  logic [31:0] prdata;
  logic pready, pslverr, sck, sck_oe_n, mosi, mosi_oe_n, miso, miso_o, miso_oe_n, irq;
  logic [15:0] last;
  logic [31:0] r;
  logic err;
  int cnt;
  int k;
  int err_total = 0;
  int cmp_count = 0;
  always #20 clk = ~clk;
  spisd_top dut (.i_clock(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_sck(s_sck), .o_sck(sck), .o_sck_oe_n(sck_oe_n), .i_mosi(s_mosi), .o_mosi(mosi),
    .o_mosi_oe_n(mosi_oe_n), .i_miso(miso), .o_miso(miso_o), .o_miso_oe_n(miso_oe_n),
    .i_slave_select_n(ss_n), .o_irq(irq));
  spisd_link_slave peer (.i_sck(sck), .i_mosi(mosi), .i_wide(wide), .o_miso(miso), .o_count(cnt),
    .o_last(last));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic fail_out();
    err_total++;
    $display("wrong value at %0t: wait ran out", $time);
    report_and_stop();
  endtask
  // One APB transfer; answer taken at the edge where pready is high, then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {22'h0, a, 2'b00};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1)
      fail_out();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task automatic irqc(input logic exp);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask
  // Poll until the transmit register is free, then queue a byte
  task automatic send(input logic [7:0] d);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, IDX_STATUS, 32'h0);
      n++;
    end
    while (r[ST_TX_EMPTY] !== 1'b1 && n < 50);
    if (r[ST_TX_EMPTY] !== 1'b1)
      fail_out();
    else
      apb(1'b1, IDX_DATA_LOW, {24'h0, d});
  endtask
  // Peer counts at its last rising edge; the block finishes a little later
  task automatic frames(input int n);
    int t;
    t = 0;
    while (cnt < n && t < 4000)
    begin
      @(posedge clk);
      t++;
    end
    if (cnt < n)
      fail_out();
    else
      repeat (20) @(posedge clk);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc(IDX_STATUS, 32'h20);
    rdc(IDX_DATA_HIGH, 32'h0);
    rdc(IDX_DATA_LOW, 32'h0);
    apb(1'b1, IDX_STATUS, 32'hFF);
    rdc(IDX_STATUS, 32'h20);
    apb(1'b0, 8'h09, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
    apb(1'b1, IDX_CTRL_ONE, 32'h50);
    k = cnt;
    send(8'hA1);
    send(8'hA2);
    chk({30'h0, sck_oe_n, mosi_oe_n}, 32'h0);
    apb(1'b1, IDX_DATA_LOW, 32'hA3);
    frames(k + 2);
    repeat (200) @(posedge clk);
    chk(32'(cnt), 32'(k + 2));
    chk({16'h0, last}, 32'hA1A2);
    rdc(IDX_STATUS, 32'hA0);
    rdc(IDX_DATA_LOW, 32'(k + 8'h50));
    rdc(IDX_STATUS, 32'hA0);
    rdc(IDX_DATA_LOW, 32'(k + 8'h51));
    rdc(IDX_STATUS, 32'h20);
    $display("test queued pair done");
    k = cnt;
    send(8'hB1);
    send(8'hB2);
    send(8'hB3);
    frames(k + 3);
    rdc(IDX_STATUS, 32'hA0);
    rdc(IDX_DATA_LOW, 32'(k + 8'h50));
    rdc(IDX_STATUS, 32'hA0);
    rdc(IDX_DATA_LOW, 32'(k + 8'h52));
    rdc(IDX_STATUS, 32'h20);
    $display("test late service done");
    wide <= 1'b1;
    apb(1'b1, IDX_CTRL_TWO, 32'h40);
    k = cnt;
    rdc(IDX_STATUS, 32'h20);
    apb(1'b1, IDX_DATA_HIGH, 32'h12);
    apb(1'b1, IDX_DATA_HIGH, 32'h34);
    rdc(IDX_STATUS, 32'h20);
    apb(1'b1, IDX_DATA_LOW, 32'h56);
    frames(k + 1);
    chk({16'h0, last}, 32'h3456);
    rdc(IDX_STATUS, 32'hA0);
    rdc(IDX_DATA_HIGH, 32'hC3);
    rdc(IDX_DATA_HIGH, 32'hC3);
    rdc(IDX_STATUS, 32'hA0);
    rdc(IDX_DATA_WORD, 32'(k + 16'hC350));
    rdc(IDX_STATUS, 32'h20);
    apb(1'b1, IDX_DATA_WORD, 32'hBEEF);
    frames(k + 2);
    chk({16'h0, last}, 32'hBEEF);
    rdc(IDX_STATUS, 32'hA0);
    rdc(IDX_DATA_LOW, 32'(k + 8'h51));
    rdc(IDX_STATUS, 32'h20);
    $display("test wide done");
    apb(1'b1, IDX_CTRL_TWO, 32'h10);
    apb(1'b1, IDX_CTRL_ONE, 32'hD0);
    apb(1'b1, IDX_MASK, 32'h04);
    ss_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk({29'h0, sck_oe_n, mosi_oe_n, miso_oe_n}, 32'h7);
    ss_n <= 1'b1;
    rdc(IDX_CTRL_ONE, 32'hC0);
    irqc(1'b1);
    apb(1'b1, IDX_CTRL_ONE, 32'hC0);
    rdc(IDX_STATUS, 32'h30);
    apb(1'b1, IDX_CTRL_ONE, 32'hC0);
    rdc(IDX_STATUS, 32'h20);
    apb(1'b1, IDX_MASK, 32'h0);
    irqc(1'b0);
    apb(1'b1, IDX_MASK, 32'h04);
    irqc(1'b1);
    apb(1'b1, IDX_EVENT, 32'h04);
    irqc(1'b0);
    $display("test mode fault done");
    // Slave frame, link clock 320 ns, driven by the bench
    rdc(IDX_STATUS, 32'h20);
    apb(1'b1, IDX_DATA_LOW, 32'h5A);
    rdc(IDX_STATUS, 32'h00);
    apb(1'b1, IDX_DATA_LOW, 32'hFF);
    ss_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk({31'h0, miso_oe_n}, 32'h0);
    for (b = 7; b >= 0; b--)
    begin
      s_mosi <= SLV_IN[b];
      repeat (4) @(posedge clk);
      got[b] = miso_o;
      s_sck <= 1'b1;
      repeat (4) @(posedge clk);
      s_sck <= 1'b0;
    end
    repeat (8) @(posedge clk);
    ss_n <= 1'b1;
    chk({24'h0, got}, 32'h5A);
    rdc(IDX_STATUS, 32'hA0);
    rdc(IDX_DATA_LOW, {24'h0, SLV_IN});
    rdc(IDX_STATUS, 32'h20);
    $display("test slave done");
    report_and_stop();
  end
endmodule
